// ### hdl/abs_enc_pkg.sv
// shared constants and types for the absolute encoder serial readout
package abs_enc_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD_0 = 2400;
    localparam int BAUD_1 = 4800;
    localparam int BAUD_2 = 9600;
    localparam int BAUD_3 = 19200;
    localparam int BAUD_4 = 38400;
    localparam int BAUD_5 = 57600;
    localparam int BAUD_6 = 115200;
    localparam int BAUD_7 = 25600;
    localparam logic [15:0] FIRST_WORD_ADDR = 16'h084D;
    localparam logic [15:0] SECOND_WORD_ADDR = 16'h084E;
    localparam logic [7:0] STATION_RESET = 8'h01;
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;
    localparam logic [7:0] FN_READ_HOLD = 8'h03;
    localparam logic [7:0] FN_EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [3:0] REQ_LEN = 4'h8;
    localparam logic [3:0] CRC_SPAN = 4'h6;
    localparam logic [23:0] GAP_BITS = 24'h000023;
    localparam logic [1:0] FRAME_NONE_2STOP = 2'h0;
    localparam logic [1:0] FRAME_EVEN_1STOP = 2'h1;
    localparam logic [1:0] FRAME_ODD_1STOP = 2'h2;
    localparam logic [1:0] FRAME_NONE_1STOP = 2'h3;
    localparam logic [3:0] BITS_SHORT = 4'hA;
    localparam logic [3:0] BITS_LONG = 4'hB;

    typedef struct packed {
        logic [7:0] station;
        logic [2:0] baud_code;
        logic [1:0] framing_code;
        logic word_order;
    } cfg_t;

    typedef struct packed {
        logic overspeed;
        logic low_battery;
        logic battery_fault;
        logic multiturn_init;
    } alarm_t;

    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} tx_state_t;
    typedef enum logic [2:0] {P_RECV = 3'b001, P_CHECK = 3'b010, P_SEND = 3'b100} proto_state_t;

    function automatic logic [16:0] baud_div(input logic [2:0] code, input int clk_hz);
        unique case (code)
            3'h0: baud_div = 17'(clk_hz / BAUD_0);
            3'h1: baud_div = 17'(clk_hz / BAUD_1);
            3'h2: baud_div = 17'(clk_hz / BAUD_2);
            3'h3: baud_div = 17'(clk_hz / BAUD_3);
            3'h4: baud_div = 17'(clk_hz / BAUD_4);
            3'h5: baud_div = 17'(clk_hz / BAUD_5);
            3'h6: baud_div = 17'(clk_hz / BAUD_6);
            3'h7: baud_div = 17'(clk_hz / BAUD_7);
        endcase
    endfunction

    function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage

// ### hdl/abs_enc_readout.sv
// serial slave readout of absolute encoder position and alarm flags
`timescale 1ns/100ps
`default_nettype none
module abs_enc_readout
    import abs_enc_pkg::*;
#(
    parameter int CLK_FREQ_HZ = CLK_HZ
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic tx_oe,
    input wire cfg_t cfg,
    input wire logic [15:0] turns_raw,
    input wire logic [15:0] single_turn,
    input wire logic sample_valid,
    input wire logic multiturn_mode,
    input wire logic battery_low,
    input wire logic battery_warn,
    input wire logic overspeed_det,
    input wire logic multiturn_lost,
    input wire logic alarm_clear_function,
    input wire logic multiturn_zeroing_function,
    output alarm_t alarms
);
    logic nrst_meta_ff, nrst_sync_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nrst_meta_ff <= 1'b0;
            nrst_sync_ff <= 1'b0;
        end else begin
            nrst_meta_ff <= 1'b1;
            nrst_sync_ff <= nrst_meta_ff;
        end
    end

    logic rx_meta_ff, rx_sync_ff;
    always_ff @(posedge mclk or negedge nrst_sync_ff) begin
        if (!nrst_sync_ff) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end else begin
            rx_meta_ff <= rx_pin;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    logic [16:0] div;
    logic has_par, odd_par;
    logic [3:0] nbits;
    assign div = baud_div(cfg.baud_code, CLK_FREQ_HZ);
    assign has_par = (cfg.framing_code == FRAME_EVEN_1STOP) || (cfg.framing_code == FRAME_ODD_1STOP);
    assign odd_par = (cfg.framing_code == FRAME_ODD_1STOP);
    assign nbits = (cfg.framing_code == FRAME_NONE_1STOP) ? BITS_SHORT : BITS_LONG;

    // receiver
    rx_state_t rx_st_ff, nxt_rx_st;
    logic [16:0] rx_cnt_ff, nxt_rx_cnt;
    logic [3:0] rx_idx_ff, nxt_rx_idx;
    logic [7:0] rx_sh_ff, nxt_rx_sh, rx_byte_ff, nxt_rx_byte;
    logic rx_par_ff, nxt_rx_par, rx_valid_ff, nxt_rx_valid, rx_err_ff, nxt_rx_err;
    always_comb begin
        nxt_rx_st = rx_st_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_idx = rx_idx_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_par = rx_par_ff;
        nxt_rx_byte = rx_byte_ff;
        nxt_rx_valid = 1'b0;
        nxt_rx_err = 1'b0;
        unique case (rx_st_ff)
            RX_IDLE: begin
                if (!rx_sync_ff) begin
                    nxt_rx_st = RX_BUSY;
                    nxt_rx_cnt = div >> 1;
                    nxt_rx_idx = 4'h0;
                end
            end
            RX_BUSY: begin
                if (rx_cnt_ff != 17'h00000) begin
                    nxt_rx_cnt = rx_cnt_ff - 17'h00001;
                end else begin
                    nxt_rx_cnt = div - 17'h00001;
                    nxt_rx_idx = rx_idx_ff + 4'h1;
                    if (rx_idx_ff == 4'h0) begin
                        if (rx_sync_ff) nxt_rx_st = RX_IDLE;
                    end else if (rx_idx_ff <= 4'h8) begin
                        nxt_rx_sh = {rx_sync_ff, rx_sh_ff[7:1]};
                    end else if (has_par && rx_idx_ff == 4'h9) begin
                        nxt_rx_par = rx_sync_ff;
                    end else begin
                        nxt_rx_st = RX_IDLE;
                        if (!rx_sync_ff || (has_par && ((^rx_sh_ff ^ rx_par_ff) != odd_par))) begin
                            nxt_rx_err = 1'b1;
                        end else begin
                            nxt_rx_valid = 1'b1;
                            nxt_rx_byte = rx_sh_ff;
                        end
                    end
                end
            end
        endcase
    end
    always_ff @(posedge mclk or negedge nrst_sync_ff) begin
        if (!nrst_sync_ff) begin
            rx_st_ff <= RX_IDLE;
            rx_cnt_ff <= 17'h00000;
            rx_idx_ff <= 4'h0;
            rx_sh_ff <= 8'h00;
            rx_par_ff <= 1'b0;
            rx_byte_ff <= 8'h00;
            rx_valid_ff <= 1'b0;
            rx_err_ff <= 1'b0;
        end else begin
            rx_st_ff <= nxt_rx_st;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_idx_ff <= nxt_rx_idx;
            rx_sh_ff <= nxt_rx_sh;
            rx_par_ff <= nxt_rx_par;
            rx_byte_ff <= nxt_rx_byte;
            rx_valid_ff <= nxt_rx_valid;
            rx_err_ff <= nxt_rx_err;
        end
    end

    // alarms and position sample
    alarm_t al_ff, nxt_al;
    logic [15:0] zero_ofs_ff, nxt_zero_ofs, pos_turn_ff, nxt_pos_turn, pos_single_ff, nxt_pos_single;
    always_comb begin
        nxt_al = al_ff;
        nxt_zero_ofs = zero_ofs_ff;
        nxt_pos_turn = pos_turn_ff;
        nxt_pos_single = pos_single_ff;
        if (alarm_clear_function) begin
            nxt_al.low_battery = 1'b0;
            nxt_al.overspeed = 1'b0;
            nxt_al.battery_fault = 1'b0;
        end
        if (multiturn_mode && battery_low) nxt_al.low_battery = 1'b1;
        if (battery_warn) nxt_al.battery_fault = 1'b1;
        if (overspeed_det) nxt_al.overspeed = 1'b1;
        if (multiturn_zeroing_function) begin
            nxt_al.multiturn_init = 1'b0;
            nxt_zero_ofs = turns_raw;
            nxt_pos_turn = 16'h0000;
        end
        if (multiturn_lost) nxt_al.multiturn_init = 1'b1;
        if (sample_valid) begin
            nxt_pos_turn = turns_raw - nxt_zero_ofs;
            nxt_pos_single = single_turn;
        end
    end
    always_ff @(posedge mclk or negedge nrst_sync_ff) begin
        if (!nrst_sync_ff) begin
            al_ff <= '{overspeed: 1'b0, low_battery: 1'b0, battery_fault: 1'b0,
                       multiturn_init: 1'b1};
            zero_ofs_ff <= 16'h0000;
            pos_turn_ff <= 16'h0000;
            pos_single_ff <= 16'h0000;
        end else begin
            al_ff <= nxt_al;
            zero_ofs_ff <= nxt_zero_ofs;
            pos_turn_ff <= nxt_pos_turn;
            pos_single_ff <= nxt_pos_single;
        end
    end
    assign alarms = al_ff;

    // request decode and reply sequencing
    proto_state_t p_ff, nxt_p;
    logic [7:0] buf_ff [0:7];
    logic [7:0] nxt_buf [0:7];
    logic [7:0] resp_ff [0:6];
    logic [7:0] nxt_resp [0:6];
    logic [3:0] bcnt_ff, nxt_bcnt, len_ff, nxt_len, tidx_ff, nxt_tidx;
    logic [15:0] crc_ff, nxt_crc;
    logic bad_ff, nxt_bad, tx_go;
    logic [23:0] gap_ff, nxt_gap, gap_lim;
    logic [7:0] tx_byte;
    logic [15:0] start, qty, w0, w1;
    logic range_ok, addr_hit;
    tx_state_t tx_st_ff;
    assign gap_lim = {7'h00, div} * GAP_BITS;
    assign start = {buf_ff[2], buf_ff[3]};
    assign qty = {buf_ff[4], buf_ff[5]};
    assign w0 = cfg.word_order ? pos_single_ff : pos_turn_ff;
    assign w1 = cfg.word_order ? pos_turn_ff : pos_single_ff;
    assign range_ok = (qty == 16'h0002 && start == FIRST_WORD_ADDR)
        || (qty == 16'h0001 && (start == FIRST_WORD_ADDR || start == SECOND_WORD_ADDR));
    assign addr_hit = (buf_ff[0] == cfg.station);
    always_comb begin
        nxt_p = p_ff;
        nxt_buf = buf_ff;
        nxt_resp = resp_ff;
        nxt_bcnt = bcnt_ff;
        nxt_len = len_ff;
        nxt_tidx = tidx_ff;
        nxt_crc = crc_ff;
        nxt_bad = bad_ff;
        nxt_gap = gap_ff;
        tx_go = 1'b0;
        tx_byte = 8'h00;
        unique case (p_ff)
            P_RECV: begin
                if (rx_valid_ff || rx_err_ff) begin
                    nxt_gap = 24'h000000;
                    if (rx_err_ff) begin
                        nxt_bad = 1'b1;
                    end else begin
                        nxt_buf[bcnt_ff[2:0]] = rx_byte_ff;
                        nxt_bcnt = bcnt_ff + 4'h1;
                        if (bcnt_ff < CRC_SPAN) nxt_crc = crc16_byte(crc_ff, rx_byte_ff);
                        if (bcnt_ff == REQ_LEN - 4'h1) nxt_p = P_CHECK;
                    end
                end else if (gap_ff >= gap_lim) begin
                    nxt_bcnt = 4'h0;
                    nxt_bad = 1'b0;
                    nxt_crc = CRC_INIT;
                end else begin
                    nxt_gap = gap_ff + 24'h000001;
                end
            end
            P_CHECK: begin
                nxt_p = P_RECV;
                nxt_bcnt = 4'h0;
                nxt_bad = 1'b0;
                nxt_crc = CRC_INIT;
                nxt_tidx = 4'h0;
                if (!bad_ff && crc_ff == {buf_ff[7], buf_ff[6]} && addr_hit
                    && buf_ff[0] != BROADCAST_ADDR) begin
                    nxt_p = P_SEND;
                    nxt_resp[0] = buf_ff[0];
                    if (buf_ff[1] != FN_READ_HOLD) begin
                        nxt_resp[1] = buf_ff[1] | FN_EXC_FLAG;
                        nxt_resp[2] = EXC_BAD_FUNC;
                        nxt_len = 4'h3;
                    end else if (!range_ok) begin
                        nxt_resp[1] = buf_ff[1] | FN_EXC_FLAG;
                        nxt_resp[2] = EXC_BAD_ADDR;
                        nxt_len = 4'h3;
                    end else begin
                        nxt_resp[1] = FN_READ_HOLD;
                        nxt_resp[2] = {qty[6:0], 1'b0};
                        {nxt_resp[3], nxt_resp[4]} = (start == SECOND_WORD_ADDR) ? w1 : w0;
                        {nxt_resp[5], nxt_resp[6]} = w1;
                        nxt_len = (qty == 16'h0002) ? 4'h7 : 4'h5;
                    end
                end
            end
            P_SEND: begin
                if (tx_st_ff == TX_IDLE) begin
                    tx_go = 1'b1;
                    nxt_tidx = tidx_ff + 4'h1;
                    if (tidx_ff < len_ff) begin
                        tx_byte = resp_ff[tidx_ff[2:0]];
                        nxt_crc = crc16_byte(crc_ff, tx_byte);
                    end else if (tidx_ff == len_ff) begin
                        tx_byte = crc_ff[7:0];
                    end else begin
                        tx_byte = crc_ff[15:8];
                        nxt_p = P_RECV;
                        nxt_crc = CRC_INIT;
                        nxt_gap = 24'h000000;
                    end
                end
            end
        endcase
    end
    always_ff @(posedge mclk or negedge nrst_sync_ff) begin
        if (!nrst_sync_ff) begin
            p_ff <= P_RECV;
            for (int i = 0; i < 8; i++) buf_ff[i] <= 8'h00;
            for (int i = 0; i < 7; i++) resp_ff[i] <= 8'h00;
            bcnt_ff <= 4'h0;
            len_ff <= 4'h0;
            tidx_ff <= 4'h0;
            crc_ff <= CRC_INIT;
            bad_ff <= 1'b0;
            gap_ff <= 24'h000000;
        end else begin
            p_ff <= nxt_p;
            buf_ff <= nxt_buf;
            resp_ff <= nxt_resp;
            bcnt_ff <= nxt_bcnt;
            len_ff <= nxt_len;
            tidx_ff <= nxt_tidx;
            crc_ff <= nxt_crc;
            bad_ff <= nxt_bad;
            gap_ff <= nxt_gap;
        end
    end

    // transmitter
    tx_state_t nxt_tx_st;
    logic [16:0] tx_cnt_ff, nxt_tx_cnt;
    logic [10:0] tx_sh_ff, nxt_tx_sh;
    logic [3:0] tx_left_ff, nxt_tx_left;
    logic tx_ff, nxt_tx, toe_ff, nxt_toe, tx_parbit;
    assign tx_parbit = has_par ? (^tx_byte ^ odd_par) : 1'b1;
    always_comb begin
        nxt_tx_st = tx_st_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_tx_left = tx_left_ff;
        nxt_tx = tx_ff;
        nxt_toe = toe_ff;
        unique case (tx_st_ff)
            TX_IDLE: begin
                nxt_tx = 1'b1;
                nxt_toe = (p_ff == P_SEND);
                if (tx_go) begin
                    nxt_tx_st = TX_BUSY;
                    nxt_tx = 1'b0;
                    nxt_tx_sh = {2'b11, tx_parbit, tx_byte};
                    nxt_tx_left = nbits;
                    nxt_tx_cnt = div - 17'h00001;
                end
            end
            TX_BUSY: begin
                if (tx_cnt_ff != 17'h00000) begin
                    nxt_tx_cnt = tx_cnt_ff - 17'h00001;
                end else if (tx_left_ff == 4'h1) begin
                    nxt_tx_st = TX_IDLE;
                    nxt_tx = 1'b1;
                    nxt_toe = (p_ff == P_SEND);
                end else begin
                    nxt_tx = tx_sh_ff[0];
                    nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
                    nxt_tx_left = tx_left_ff - 4'h1;
                    nxt_tx_cnt = div - 17'h00001;
                end
            end
        endcase
    end
    always_ff @(posedge mclk or negedge nrst_sync_ff) begin
        if (!nrst_sync_ff) begin
            tx_st_ff <= TX_IDLE;
            tx_cnt_ff <= 17'h00000;
            tx_sh_ff <= 11'h7FF;
            tx_left_ff <= 4'h0;
            tx_ff <= 1'b1;
            toe_ff <= 1'b0;
        end else begin
            tx_st_ff <= nxt_tx_st;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_sh_ff <= nxt_tx_sh;
            tx_left_ff <= nxt_tx_left;
            tx_ff <= nxt_tx;
            toe_ff <= nxt_toe;
        end
    end
    assign tx_pin = tx_ff;
    assign tx_oe = toe_ff;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst_sync_ff);
    chk_station_mismatch: assert property (
        p_ff == P_CHECK && !addr_hit |=> p_ff == P_RECV) else $error("foreign station answered");
    chk_bit_period: assert property (
        tx_st_ff == TX_BUSY && tx_cnt_ff == 17'h00000 && tx_left_ff != 4'h1
        |=> tx_cnt_ff == $past(div) - 17'h00001) else $error("bit period wrong");
    chk_frame_len: assert property (
        tx_st_ff == TX_IDLE && tx_go |=> tx_left_ff == (cfg.framing_code == FRAME_NONE_1STOP ? 4'hA : 4'hB))
        else $error("frame length wrong");
    chk_word_order: assert property (
        p_ff == P_CHECK ##1 p_ff == P_SEND && len_ff == 4'h7
        |-> {resp_ff[3], resp_ff[4]} == $past(cfg.word_order ? pos_single_ff : pos_turn_ff))
        else $error("word order wrong");
    chk_reply_len: assert property (
        p_ff == P_CHECK && addr_hit && range_ok && buf_ff[1] == FN_READ_HOLD && !bad_ff
        && crc_ff == {buf_ff[7], buf_ff[6]} && qty == 16'h0002 |=> len_ff == 4'h7 && p_ff == P_SEND)
        else $error("two word read not served");
    chk_init_alarm: assert property (
        multiturn_lost |=> al_ff.multiturn_init) else $error("init alarm missing");
    chk_zeroing: assert property (
        multiturn_zeroing_function && !multiturn_lost && !sample_valid
        |=> !al_ff.multiturn_init && pos_turn_ff == 16'h0000) else $error("zeroing failed");
    chk_low_batt: assert property (
        multiturn_mode && battery_low |=> al_ff.low_battery) else $error("low battery missed");
    chk_batt_fault: assert property (
        battery_warn |=> al_ff.battery_fault) else $error("battery fault missed");
    chk_low_batt_clear: assert property (
        alarm_clear_function && !(multiturn_mode && battery_low) |=> !al_ff.low_battery)
        else $error("low battery not cleared");
    chk_overspeed: assert property (
        overspeed_det ##1 !alarm_clear_function [*2] |=> al_ff.overspeed)
        else $error("overspeed lost");
    chk_same_sample: assert property (
        p_ff == P_CHECK ##1 p_ff == P_SEND && len_ff == 4'h7
        |-> {resp_ff[3], resp_ff[4], resp_ff[5], resp_ff[6]} == $past({w0, w1}))
        else $error("words from different samples");
    cov_read_two: cover property (p_ff == P_SEND && len_ff == 4'h7);
    cov_exception: cover property (p_ff == P_SEND && len_ff == 4'h3);
    cov_rx_error: cover property (rx_err_ff);
    cov_zeroing: cover property (al_ff.multiturn_init ##1 !al_ff.multiturn_init);
endmodule // abs_enc_readout
`default_nettype wire

// ### testbench/host_master.sv
// host serial master model driving requests and sampling replies
`timescale 1ns/100ps
`default_nettype none
module host_master #(
    parameter int DIV = 2170
) (
    input wire logic mclk,
    input wire logic line_in,
    input wire logic [1:0] fr,
    output var logic line_out
);
    initial line_out = 1'b1;

    // one bit held for a full bit time at the shared rate
    task automatic put_bit(input logic b);
        line_out <= b;
        repeat (DIV) @(posedge mclk);
    endtask

    task automatic send(input logic [7:0] b, input logic last);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) put_bit(b[i]);
        if (fr == 2'h1 || fr == 2'h2) put_bit(^b ^ (fr == 2'h2));
        // line stays high; hand over mid stop bit after the last byte
        line_out <= 1'b1;
        repeat (last ? DIV / 2 : DIV) @(posedge mclk);
        if (fr == 2'h0 && !last) put_bit(1'b1);
    endtask

    // bounded wait for a start bit, then mid-bit sampling
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        while (line_in !== 1'b0 && n < 40 * DIV) begin
            @(posedge mclk);
            n++;
        end
        repeat (DIV / 2) @(posedge mclk);
        ok = (n < 40 * DIV) && (line_in === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge mclk);
            b[i] = line_in;
        end
        if (fr == 2'h1 || fr == 2'h2) begin
            repeat (DIV) @(posedge mclk);
            ok &= (line_in === (^b ^ (fr == 2'h2)));
        end
        repeat (DIV) @(posedge mclk);
        ok &= (line_in === 1'b1);
    endtask
endmodule // host_master
`default_nettype wire

// ### testbench/test_abs_enc_readout.sv
// self-checking bench for the absolute encoder serial readout
`timescale 1ns/100ps
`default_nettype none
module test_abs_enc_readout;
    import abs_enc_pkg::*;
    // scaled divider base keeps the run short
    localparam int CLK_FREQ_HZ = 1_843_200;
    localparam int DIV = CLK_FREQ_HZ / 115200;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic tx_pin;
    logic tx_oe;
    wire logic rx_pin;
    // released line is pulled high
    wire logic line_dev = tx_oe ? tx_pin : 1'b1;
    cfg_t cfg = {8'h2C, 3'h6, 2'h1, 1'b0};
    logic [15:0] turns_raw = 16'h0000;
    logic [15:0] single_turn = 16'h0000;
    // sample, mode, low, warn, overspeed, lost, clear, zero
    logic [7:0] ctl = 8'h00;
    alarm_t alarms;
    int n_fail = 0;
    int num_checks = 0;

    always #2 mclk = ~mclk;

    abs_enc_readout #(.CLK_FREQ_HZ(CLK_FREQ_HZ)) DUT (.mclk(mclk), .nrst(nrst), .rx_pin(rx_pin),
        .tx_pin(tx_pin),
        .tx_oe(tx_oe), .cfg(cfg), .turns_raw(turns_raw), .single_turn(single_turn),
        .sample_valid(ctl[7]), .multiturn_mode(ctl[6]), .battery_low(ctl[5]),
        .battery_warn(ctl[4]), .overspeed_det(ctl[3]), .multiturn_lost(ctl[2]),
        .alarm_clear_function(ctl[1]), .multiturn_zeroing_function(ctl[0]),
        .alarms(alarms));

    host_master #(.DIV(DIV)) host (.mclk(mclk), .line_in(line_dev),
        .fr(cfg.framing_code), .line_out(rx_pin));

    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // apply inputs, drop the pulse bits after one cycle, then compare alarms
    task automatic put(input logic [7:0] v, input logic [15:0] exp);
        @(posedge mclk);
        ctl <= v;
        @(posedge mclk);
        ctl <= v & 8'h7C;
        repeat (2) @(posedge mclk);
        #1;
        check("alarms", exp, {12'h000, alarms});
    endtask

    function automatic logic [15:0] crc(input logic [7:0] m[12], input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            c ^= {8'h00, m[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction

    // one read request and its full reply, or a check for silence when the station is foreign
    task automatic xfer(input logic [7:0] st, input logic [15:0] a, input logic [7:0] q,
            input logic [15:0] w0, input logic [15:0] w1);
        logic [7:0] m[12];
        logic [7:0] b;
        logic ok;
        logic [15:0] c;
        int n;
        m = '{default: 8'h00};
        m[0] = st;
        m[1] = 8'h03;
        m[2] = a[15:8];
        m[3] = a[7:0];
        m[5] = q;
        c = crc(m, 6);
        m[6] = c[7:0];
        m[7] = c[15:8];
        for (int i = 0; i < 8; i++) host.send(m[i], i == 7);
        if (st != cfg.station) begin
            host.recv(b, ok);
            check("foreign silence", 16'h0000, {15'h0000, ok});
        end else begin
            m[2] = 8'(2 * q);
            m[3] = w0[15:8];
            m[4] = w0[7:0];
            m[5] = w1[15:8];
            m[6] = w1[7:0];
            n = 3 + 2 * int'(q);
            c = crc(m, n);
            m[n] = c[7:0];
            m[n + 1] = c[15:8];
            for (int i = 0; i < n + 2; i++) begin
                host.recv(b, ok);
                check("reply framing", 16'h0001, {15'h0000, ok});
                check("reply byte", {8'h00, m[i]}, {8'h00, b});
                if (ok !== 1'b1) test_done();
            end
        end
        repeat (36 * DIV) @(posedge mclk);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        put(8'h00, 16'h0001);
        put(8'h80, 16'h0001);
        put(8'h01, 16'h0000);
        put(8'h04, 16'h0001);
        put(8'h01, 16'h0000);
        put(8'h20, 16'h0000);
        put(8'h60, 16'h0004);
        put(8'h70, 16'h0006);
        put(8'h00, 16'h0006);
        put(8'h02, 16'h0000);
        put(8'h08, 16'h0008);
        put(8'h02, 16'h0000);
        @(posedge mclk);
        turns_raw <= 16'h1234;
        single_turn <= 16'hABCD;
        put(8'h80, 16'h0000);
        @(posedge mclk);
        turns_raw <= 16'h5555;
        xfer(8'h2C, 16'h084D, 8'h02, 16'h1234, 16'hABCD);
        @(posedge mclk);
        cfg <= {8'hC3, 3'h6, 2'h2, 1'b1};
        repeat (4) @(posedge mclk);
        xfer(8'hC3, 16'h084E, 8'h01, 16'h1234, 16'h0000);
        @(posedge mclk);
        cfg <= {8'hC3, 3'h6, 2'h0, 1'b0};
        repeat (4) @(posedge mclk);
        xfer(8'hC3, 16'h084E, 8'h01, 16'hABCD, 16'h0000);
        @(posedge mclk);
        cfg <= {8'hC3, 3'h6, 2'h3, 1'b0};
        repeat (4) @(posedge mclk);
        xfer(8'h2C, 16'h084D, 8'h02, 16'h0000, 16'h0000);
        xfer(8'hC3, 16'h084D, 8'h02, 16'h1234, 16'hABCD);
        test_done();
    end
endmodule // test_abs_enc_readout
`default_nettype wire
